// [hdl/dctg_guard_regs.vh]
// Constants for the DDR4 command timing guard
`ifndef DCTG_GUARD_REGS_VH
`define DCTG_GUARD_REGS_VH

// Command codes on the pending and issued command ports
`define DCTG_CMD_ACT        2'h0
`define DCTG_CMD_RD         2'h1
`define DCTG_CMD_WR         2'h2
`define DCTG_CMD_REF        2'h3

// Memory clock period in ns, used to turn ns settings into cycles
`define DCTG_CLK_PERIOD_NS  12'h00A
// Cycles per 0.1 us unit of the refresh interval setting
`define DCTG_CYC_PER_100NS  16'h000A

// Owed refreshes at which a rank stops taking new work
`define DCTG_REF_DEBT_MAX   4'h8

// Reset values
`define DCTG_TIMER_RST      12'h000
`define DCTG_DEBT_RST       4'h0
`define DCTG_PTR_RST        2'h0
`define DCTG_TICK_RST       16'h0000

`endif

// [hdl/dctg_guard.v]
// DDR4 command spacing guard between scheduler and memory command port
// What this block does
// - Activates to different bank groups in one rank keep the short activate spacing.
// - Activates to the same bank group in one rank keep the long activate spacing.
// - Stacked devices: activates to different logical ranks keep cross-rank spacing.
// - At most four activates per rank inside the four-activate window.
// - Stacked devices: at most four activates across all ranks in cross-rank window.
// - Column commands to different bank groups keep the short column spacing.
// - Column commands to the same bank group keep the long column spacing.
// - Read to another bank group waits short write-to-read after write data ends.
// - Read to the same bank group waits long write-to-read after write data ends.
// - No activate to a rank until refresh recovery has elapsed after its refresh.
// - Stacked devices: activate to another rank waits cross-rank refresh recovery.
// - Refreshes are demanded so their average spacing stays within the interval.
`include "dctg_guard_regs.vh"

module dctg_guard (
    input  wire        clock,
    input  wire        sys_rst,
    input  wire        stackedMode,
    input  wire [11:0] actSpacingDiffGroupCycles,
    input  wire [11:0] actSpacingSameGroupCycles,
    input  wire [11:0] actSpacingCrossRankCycles,
    input  wire [11:0] fourActWindowNs,
    input  wire [11:0] fourActWindowCrossRankCycles,
    input  wire [11:0] colSpacingDiffGroupCycles,
    input  wire [11:0] colSpacingSameGroupCycles,
    input  wire [11:0] wrToRdDiffGroupCycles,
    input  wire [11:0] wrToRdSameGroupCycles,
    input  wire [11:0] wrDataEndCycles,
    input  wire [11:0] refreshRecoveryNs,
    input  wire [11:0] refreshRecoveryCrossRankNs,
    input  wire [15:0] refreshIntervalUs,
    input  wire        cmdValid,
    input  wire [1:0]  cmdType,
    input  wire [1:0]  cmdRank,
    input  wire [1:0]  cmdGroup,
    output reg         cmdReady_r,
    output reg         issueValid_r,
    output reg  [1:0]  issueType_r,
    output reg  [1:0]  issueRank_r,
    output reg  [1:0]  issueGroup_r,
    output reg  [3:0]  refreshDue_r,
    output reg  [3:0]  refreshUrgent_r
);

    // Countdown load: a spacing of N cycles reaches zero N cycles after issue
    function [11:0] ld;
        input [11:0] n;
        begin
            ld = (n == 12'h000) ? 12'h000 : n - 12'h001;
        end
    endfunction

    function [11:0] mx;
        input [11:0] a;
        input [11:0] b;
        begin
            mx = (a > b) ? a : b;
        end
    endfunction

    function [11:0] dec;
        input [11:0] a;
        begin
            dec = (a == 12'h000) ? 12'h000 : a - 12'h001;
        end
    endfunction

    // Unit conversion; refresh interval is in tenths of a microsecond
    wire [11:0] fawCyc    = (fourActWindowNs + `DCTG_CLK_PERIOD_NS - 12'h001) / `DCTG_CLK_PERIOD_NS;
    wire [11:0] rfcCyc    = (refreshRecoveryNs + `DCTG_CLK_PERIOD_NS - 12'h001) / `DCTG_CLK_PERIOD_NS;
    wire [11:0] rfcDlrCyc = (refreshRecoveryCrossRankNs + `DCTG_CLK_PERIOD_NS - 12'h001)
                            / `DCTG_CLK_PERIOD_NS;
    wire [31:0] refIntWide = {16'h0000, refreshIntervalUs} * {16'h0000, `DCTG_CYC_PER_100NS};
    wire [15:0] refIntCyc  = (refIntWide[31:16] != 16'h0000) ? 16'hFFFF : refIntWide[15:0];

    reg         pendValid_r;
    reg  [1:0]  pendType_r;
    reg  [1:0]  pendRank_r;
    reg  [1:0]  pendGroup_r;

    reg  [11:0] actGrp_r   [0:15];
    reg  [11:0] actRank_r  [0:3];
    reg  [11:0] actBlock_r [0:3];
    reg  [11:0] faw_r      [0:15];
    reg  [1:0]  fawPtr_r   [0:3];
    reg  [11:0] fawX_r     [0:3];
    reg  [1:0]  fawXPtr_r;
    reg  [11:0] colGrp_r   [0:3];
    reg  [11:0] wtr_r      [0:3];
    reg  [3:0]  debt_r     [0:3];
    reg  [15:0] refTick_r;

    wire [3:0]  pendRg   = {pendRank_r, pendGroup_r};
    wire [3:0]  pendSlot = {pendRank_r, fawPtr_r[pendRank_r]};

    reg issueOk;
    always @* begin
        case (pendType_r)
            `DCTG_CMD_ACT: issueOk = (actGrp_r[pendRg] == 12'h000)
                                  && (actRank_r[pendRank_r] == 12'h000)
                                  && (actBlock_r[pendRank_r] == 12'h000)
                                  && (faw_r[pendSlot] == 12'h000)
                                  && (!stackedMode || fawX_r[fawXPtr_r] == 12'h000)
                                  && !refreshUrgent_r[pendRank_r];
            `DCTG_CMD_RD:  issueOk = (colGrp_r[pendGroup_r] == 12'h000)
                                  && (wtr_r[pendGroup_r] == 12'h000)
                                  && !refreshUrgent_r[pendRank_r];
            `DCTG_CMD_WR:  issueOk = (colGrp_r[pendGroup_r] == 12'h000)
                                  && !refreshUrgent_r[pendRank_r];
            default:       issueOk = 1'b1;
        endcase
    end

    // All limits are checked in the same cycle; otherwise the command waits
    wire issue    = pendValid_r && issueOk;
    wire accept   = cmdValid && cmdReady_r;
    wire issueAct = issue && (pendType_r == `DCTG_CMD_ACT);
    wire issueRef = issue && (pendType_r == `DCTG_CMD_REF);
    wire issueWr  = issue && (pendType_r == `DCTG_CMD_WR);
    wire issueCol = issue && (pendType_r == `DCTG_CMD_RD || pendType_r == `DCTG_CMD_WR);
    wire pendValid_nxt = accept | (pendValid_r & ~issue);

    // One-entry holding stage; ready is the registered inverse of occupancy
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pendValid_r  <= 1'b0;
            pendType_r   <= `DCTG_CMD_ACT;
            pendRank_r   <= 2'h0;
            pendGroup_r  <= 2'h0;
            cmdReady_r   <= 1'b0;
            issueValid_r <= 1'b0;
            issueType_r  <= `DCTG_CMD_ACT;
            issueRank_r  <= 2'h0;
            issueGroup_r <= 2'h0;
            fawXPtr_r    <= `DCTG_PTR_RST;
            refTick_r    <= `DCTG_TICK_RST;
        end else begin
            pendValid_r  <= pendValid_nxt;
            cmdReady_r   <= ~pendValid_nxt;
            if (accept) begin
                pendType_r  <= cmdType;
                pendRank_r  <= cmdRank;
                pendGroup_r <= cmdGroup;
            end
            issueValid_r <= issue;
            if (issue) begin
                issueType_r  <= pendType_r;
                issueRank_r  <= pendRank_r;
                issueGroup_r <= pendGroup_r;
            end
            if (issueAct && stackedMode)
                fawXPtr_r <= fawXPtr_r + 2'h1;
            // Interval counted in whole cycles, saturating at 16'hFFFF
            if (refTick_r >= refIntCyc - 16'h0001)
                refTick_r <= `DCTG_TICK_RST;
            else
                refTick_r <= refTick_r + 16'h0001;
        end
    end

    wire refTick = (refTick_r >= refIntCyc - 16'h0001);

    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1) begin : gRankGroup
            always @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    actGrp_r[i] <= `DCTG_TIMER_RST;
                    faw_r[i]    <= `DCTG_TIMER_RST;
                end else begin
                    if (issueAct && pendRg == i)
                        actGrp_r[i] <= mx(dec(actGrp_r[i]), ld(actSpacingSameGroupCycles));
                    else
                        actGrp_r[i] <= dec(actGrp_r[i]);
                    // Oldest of the four slots per rank is reloaded by each activate
                    if (issueAct && pendSlot == i)
                        faw_r[i] <= ld(fawCyc);
                    else
                        faw_r[i] <= dec(faw_r[i]);
                end
            end
        end

        for (i = 0; i < 4; i = i + 1) begin : gRank
            always @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    actRank_r[i]    <= `DCTG_TIMER_RST;
                    actBlock_r[i]   <= `DCTG_TIMER_RST;
                    fawPtr_r[i]     <= `DCTG_PTR_RST;
                    debt_r[i]       <= `DCTG_DEBT_RST;
                    refreshDue_r[i] <= 1'b0;
                    refreshUrgent_r[i] <= 1'b0;
                end else begin
                    if (issueAct && pendRank_r == i)
                        actRank_r[i] <= mx(dec(actRank_r[i]), ld(actSpacingDiffGroupCycles));
                    else if (issueAct && stackedMode)
                        actRank_r[i] <= mx(dec(actRank_r[i]), ld(actSpacingCrossRankCycles));
                    else
                        actRank_r[i] <= dec(actRank_r[i]);
                    if (issueRef && pendRank_r == i)
                        actBlock_r[i] <= mx(dec(actBlock_r[i]), ld(rfcCyc));
                    else if (issueRef && stackedMode)
                        actBlock_r[i] <= mx(dec(actBlock_r[i]), ld(rfcDlrCyc));
                    else
                        actBlock_r[i] <= dec(actBlock_r[i]);
                    if (issueAct && pendRank_r == i)
                        fawPtr_r[i] <= fawPtr_r[i] + 2'h1;
                    // Owed refreshes: a new tick and a refresh in one cycle cancel out
                    case ({refTick, issueRef && pendRank_r == i})
                        2'b10: if (debt_r[i] != `DCTG_REF_DEBT_MAX) debt_r[i] <= debt_r[i] + 4'h1;
                        2'b01: if (debt_r[i] != `DCTG_DEBT_RST) debt_r[i] <= debt_r[i] - 4'h1;
                        default: debt_r[i] <= debt_r[i];
                    endcase
                    refreshDue_r[i]    <= (debt_r[i] != `DCTG_DEBT_RST);
                    refreshUrgent_r[i] <= (debt_r[i] == `DCTG_REF_DEBT_MAX);
                end
            end
        end

        for (i = 0; i < 4; i = i + 1) begin : gGroup
            always @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    colGrp_r[i] <= `DCTG_TIMER_RST;
                    wtr_r[i]    <= `DCTG_TIMER_RST;
                    fawX_r[i]   <= `DCTG_TIMER_RST;
                end else begin
                    if (issueCol && pendGroup_r == i)
                        colGrp_r[i] <= mx(dec(colGrp_r[i]), ld(colSpacingSameGroupCycles));
                    else if (issueCol)
                        colGrp_r[i] <= mx(dec(colGrp_r[i]), ld(colSpacingDiffGroupCycles));
                    else
                        colGrp_r[i] <= dec(colGrp_r[i]);
                    // Counted from the write command plus the time until its data ends
                    if (issueWr && pendGroup_r == i)
                        wtr_r[i] <= mx(dec(wtr_r[i]), ld(wrDataEndCycles + wrToRdSameGroupCycles));
                    else if (issueWr)
                        wtr_r[i] <= mx(dec(wtr_r[i]), ld(wrDataEndCycles + wrToRdDiffGroupCycles));
                    else
                        wtr_r[i] <= dec(wtr_r[i]);
                    if (issueAct && stackedMode && fawXPtr_r == i)
                        fawX_r[i] <= ld(fourActWindowCrossRankCycles);
                    else
                        fawX_r[i] <= dec(fawX_r[i]);
                end
            end
        end
    endgenerate

endmodule // dctg_guard

// [verification/dctg_guard_props.sv]
// Spacing checker on the guard's issued command stream
`include "dctg_guard_regs.vh"
module dctg_guard_props (
    input logic        clock,
    input logic        sys_rst,
    input logic        stackedMode,
    input logic [11:0] actSpacingDiffGroupCycles,
    input logic [11:0] actSpacingSameGroupCycles,
    input logic [11:0] actSpacingCrossRankCycles,
    input logic [11:0] colSpacingDiffGroupCycles,
    input logic [11:0] colSpacingSameGroupCycles,
    input logic [11:0] wrToRdDiffGroupCycles,
    input logic [11:0] wrToRdSameGroupCycles,
    input logic [11:0] wrDataEndCycles,
    input logic [11:0] refreshRecoveryNs,
    input logic        cmdValid,
    input logic        cmdReady_r,
    input logic        issueValid_r,
    input logic [1:0]  issueType_r,
    input logic [1:0]  issueRank_r,
    input logic [1:0]  issueGroup_r
);
    timeunit 1ns;
    timeprecision 1ps;
    // Counters saturate so an old command never looks recent again
    logic [11:0] sAct_r, sCol_r, sWr_r, sRef_r;
    logic [1:0]  aRank_r, aGrp_r, cGrp_r, wGrp_r, fRank_r;
    wire isAct = issueValid_r && issueType_r == `DCTG_CMD_ACT;
    wire isRd  = issueValid_r && issueType_r == `DCTG_CMD_RD;
    wire isWr  = issueValid_r && issueType_r == `DCTG_CMD_WR;
    wire isRef = issueValid_r && issueType_r == `DCTG_CMD_REF;
    function automatic [11:0] inc(input [11:0] v);
        inc = (v == 12'hFFF) ? v : v + 12'h001;
    endfunction
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            {sAct_r, sCol_r, sWr_r, sRef_r} <= {4{12'hFFF}};
            {aRank_r, aGrp_r, cGrp_r, wGrp_r, fRank_r} <= 10'h000;
        end else begin
            sAct_r <= isAct ? 12'h001 : inc(sAct_r);
            sCol_r <= (isRd || isWr) ? 12'h001 : inc(sCol_r);
            sWr_r <= isWr ? 12'h001 : inc(sWr_r);
            sRef_r <= isRef ? 12'h001 : inc(sRef_r);
            if (isAct) {aRank_r, aGrp_r} <= {issueRank_r, issueGroup_r};
            if (isRd || isWr) cGrp_r <= issueGroup_r;
            if (isWr) wGrp_r <= issueGroup_r;
            if (isRef) fRank_r <= issueRank_r;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    a_act_same_grp: assert property (isAct && issueRank_r == aRank_r && issueGroup_r == aGrp_r
        |-> sAct_r >= actSpacingSameGroupCycles) else $error("activates to one group too close");
    a_act_diff_grp: assert property (isAct && issueRank_r == aRank_r && issueGroup_r != aGrp_r
        |-> sAct_r >= actSpacingDiffGroupCycles) else $error("activates to two groups too close");
    a_act_cross_rank: assert property (stackedMode && isAct && issueRank_r != aRank_r
        |-> sAct_r >= actSpacingCrossRankCycles) else $error("activates across ranks too close");
    a_col_same_grp: assert property ((isRd || isWr) && issueGroup_r == cGrp_r
        |-> sCol_r >= colSpacingSameGroupCycles) else $error("column commands one group too close");
    a_col_diff_grp: assert property ((isRd || isWr) && issueGroup_r != cGrp_r
        |-> sCol_r >= colSpacingDiffGroupCycles) else $error("column commands two groups too close");
    a_wr_rd_same: assert property (isRd && issueGroup_r == wGrp_r
        |-> {1'b0, sWr_r} >= {1'b0, wrDataEndCycles} + {1'b0, wrToRdSameGroupCycles})
        else $error("read too soon after write");
    a_wr_rd_diff: assert property (isRd && issueGroup_r != wGrp_r
        |-> {1'b0, sWr_r} >= {1'b0, wrDataEndCycles} + {1'b0, wrToRdDiffGroupCycles})
        else $error("read to other group too soon after write");
    a_ref_recovery: assert property (isAct && issueRank_r == fRank_r
        |-> {4'h0, sRef_r} * 16'h000A >= {4'h0, refreshRecoveryNs}) else $error("activate inside recovery");
    a_issue_pulse: assert property (issueValid_r |=> !issueValid_r) else $error("issue pulse too long");
    a_take_busy: assert property (cmdValid && cmdReady_r |=> !cmdReady_r) else $error("stage not busy");
    a_issue_ready: assert property (issueValid_r |-> cmdReady_r) else $error("stage not freed on issue");
endmodule // dctg_guard_props
bind dctg_guard dctg_guard_props u_props (
    .clock(clock), .sys_rst(sys_rst), .stackedMode(stackedMode),
    .actSpacingDiffGroupCycles(actSpacingDiffGroupCycles), .actSpacingSameGroupCycles(actSpacingSameGroupCycles),
    .actSpacingCrossRankCycles(actSpacingCrossRankCycles), .colSpacingDiffGroupCycles(colSpacingDiffGroupCycles),
    .colSpacingSameGroupCycles(colSpacingSameGroupCycles), .wrToRdDiffGroupCycles(wrToRdDiffGroupCycles),
    .wrToRdSameGroupCycles(wrToRdSameGroupCycles), .wrDataEndCycles(wrDataEndCycles),
    .refreshRecoveryNs(refreshRecoveryNs), .cmdValid(cmdValid), .cmdReady_r(cmdReady_r),
    .issueValid_r(issueValid_r), .issueType_r(issueType_r), .issueRank_r(issueRank_r), .issueGroup_r(issueGroup_r)
);

// [verification/dctg_mem_model.sv]
// Memory side: logs the cycle of every released command
module dctg_mem_model (
    input logic clock,
    input logic issueValid
);
    timeunit 1ns;
    timeprecision 1ps;
    int cyc = 0;
    int times[$];
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (issueValid) times.push_back(cyc);
    end
endmodule // dctg_mem_model

// [verification/dctg_guard_tb.sv]
// Self-checking bench for the command spacing guard
`include "dctg_guard_regs.vh"
module dctg_guard_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] ACT = `DCTG_CMD_ACT, RD = `DCTG_CMD_RD, WR = `DCTG_CMD_WR, REF = `DCTG_CMD_REF;
    logic clock = 1'b0, sys_rst = 1'b1, stackedMode = 1'b0, cmdValid = 1'b0;
    logic [1:0] cmdType = 2'h0, cmdRank = 2'h0, cmdGroup = 2'h0;
    logic [11:0] actSpacingDiffGroupCycles = 12'h004, actSpacingSameGroupCycles = 12'h007;
    logic [11:0] actSpacingCrossRankCycles = 12'h006, fourActWindowNs = 12'h0EB;
    logic [11:0] fourActWindowCrossRankCycles = 12'h022, colSpacingDiffGroupCycles = 12'h005;
    logic [11:0] colSpacingSameGroupCycles = 12'h008, wrToRdDiffGroupCycles = 12'h004;
    logic [11:0] wrToRdSameGroupCycles = 12'h006, wrDataEndCycles = 12'h006;
    logic [11:0] refreshRecoveryNs = 12'h09B, refreshRecoveryCrossRankNs = 12'h055;
    logic [15:0] refreshIntervalUs = 16'h00C8;
    logic cmdReady_r, issueValid_r;
    logic [1:0] issueType_r, issueRank_r, issueGroup_r;
    logic [3:0] refreshDue_r, refreshUrgent_r;
    int n_fail = 0, checked = 0;
    dctg_guard u_dut (
        .clock(clock), .sys_rst(sys_rst), .stackedMode(stackedMode),
        .actSpacingDiffGroupCycles(actSpacingDiffGroupCycles), .actSpacingSameGroupCycles(actSpacingSameGroupCycles),
        .actSpacingCrossRankCycles(actSpacingCrossRankCycles), .fourActWindowNs(fourActWindowNs),
        .fourActWindowCrossRankCycles(fourActWindowCrossRankCycles),
        .colSpacingDiffGroupCycles(colSpacingDiffGroupCycles), .colSpacingSameGroupCycles(colSpacingSameGroupCycles),
        .wrToRdDiffGroupCycles(wrToRdDiffGroupCycles), .wrToRdSameGroupCycles(wrToRdSameGroupCycles),
        .wrDataEndCycles(wrDataEndCycles), .refreshRecoveryNs(refreshRecoveryNs),
        .refreshRecoveryCrossRankNs(refreshRecoveryCrossRankNs), .refreshIntervalUs(refreshIntervalUs),
        .cmdValid(cmdValid), .cmdType(cmdType), .cmdRank(cmdRank), .cmdGroup(cmdGroup),
        .cmdReady_r(cmdReady_r), .issueValid_r(issueValid_r), .issueType_r(issueType_r),
        .issueRank_r(issueRank_r), .issueGroup_r(issueGroup_r), .refreshDue_r(refreshDue_r),
        .refreshUrgent_r(refreshUrgent_r)
    );
    dctg_mem_model u_mem (.clock(clock), .issueValid(issueValid_r));
    always #5 clock = ~clock;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Holds the request until the edge that takes it; stays valid for a follow-on
    task automatic send(input logic [1:0] t, input logic [1:0] r, input logic [1:0] g);
        int k;
        cmdValid <= 1'b1;
        cmdType <= t;
        cmdRank <= r;
        cmdGroup <= g;
        k = 0;
        do begin @(negedge clock); k++; end while (!cmdReady_r && k < 300);
        @(posedge clock);
    endtask
    // Gap from first to n-th release; idle long enough to clear every window
    task automatic span(input int n, input int exp);
        int k;
        cmdValid <= 1'b0;
        k = 0;
        while (u_mem.times.size() < n && k < 500) begin @(posedge clock); k++; end
        check(16'(u_mem.times[n-1] - u_mem.times[0]), 16'(exp));
        repeat (60) @(posedge clock);
        check(16'(u_mem.times.size()), 16'(n));
        u_mem.times.delete();
    endtask
    task automatic t_act();
        send(ACT, 2'h0, 2'h0); send(ACT, 2'h0, 2'h0); span(2, 7);
        send(ACT, 2'h0, 2'h0); send(ACT, 2'h0, 2'h1); span(2, 4);
        stackedMode <= 1'b1;
        send(ACT, 2'h0, 2'h0); send(ACT, 2'h1, 2'h0); span(2, 6);
    endtask
    // Per-rank window with stacking off, as the longer cross-rank window would hide it; then the cross-rank window
    task automatic t_faw();
        stackedMode <= 1'b0;
        for (int i = 0; i < 4; i++) send(ACT, 2'h0, 2'(i));
        send(ACT, 2'h0, 2'h0); span(5, 24);
        stackedMode <= 1'b1;
        for (int i = 0; i < 4; i++) send(ACT, 2'(i), 2'h0);
        send(ACT, 2'h0, 2'h1); span(5, 34);
    endtask
    task automatic t_col();
        send(RD, 2'h0, 2'h0); send(RD, 2'h0, 2'h1); span(2, 5);
        send(RD, 2'h0, 2'h0); send(WR, 2'h1, 2'h0); span(2, 8);
        send(WR, 2'h0, 2'h0); send(RD, 2'h0, 2'h1); span(2, 10);
        send(WR, 2'h0, 2'h2); send(RD, 2'h0, 2'h2); span(2, 12);
    endtask
    task automatic t_ref();
        send(REF, 2'h0, 2'h0); send(ACT, 2'h0, 2'h0); span(2, 16);
        send(REF, 2'h0, 2'h0); send(ACT, 2'h1, 2'h0); span(2, 9);
        stackedMode <= 1'b0;
    endtask
    // Interval of 200 tenths of a microsecond is 2000 cycles
    task automatic t_due();
        int k;
        k = 0;
        while (refreshDue_r === 4'h0 && k < 2100) begin @(posedge clock); k++; end
        check(refreshDue_r, 4'hF);
        send(REF, 2'h2, 2'h0); span(1, 0);
        check(issueType_r, REF);
        check(issueRank_r, 2'h2);
        check(issueGroup_r, 2'h0);
        check(refreshDue_r, 4'hB);
        check(refreshUrgent_r, 4'h0);
    endtask
    // Debt piles up on a short interval; a held activate is cleared only by reset
    task automatic t_urg();
        int k;
        refreshIntervalUs <= 16'h0001;
        k = 0;
        while (refreshUrgent_r !== 4'hF && k < 300) begin @(posedge clock); k++; end
        check(refreshUrgent_r, 4'hF);
        send(ACT, 2'h0, 2'h0);
        cmdValid <= 1'b0;
        repeat (30) @(posedge clock);
        check(16'(u_mem.times.size()), 16'h0000);
        check(cmdReady_r, 1'b0);
        sys_rst <= 1'b1;
        refreshIntervalUs <= 16'h00C8;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clock);
        check(cmdReady_r, 1'b1);
        check(refreshDue_r, 4'h0);
        check(refreshUrgent_r, 4'h0);
        send(ACT, 2'h0, 2'h1); send(ACT, 2'h0, 2'h1); span(2, 7);
    endtask
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #300000;
        n_fail++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clock);
        check(cmdReady_r, 1'b1);
        t_act();
        t_faw();
        t_col();
        t_ref();
        t_due();
        t_urg();
        close_out();
    end
endmodule // dctg_guard_tb
